// *** grx_consts.vh ***
// constants for the rate sensor interrupt unit
`ifndef GRX_CONSTS_VH
`define GRX_CONSTS_VH

// register offsets (6-bit address)
`define GRX_A_UL_STS      6'h00
`define GRX_A_PA_STS      6'h01
`define GRX_A_PB_STS      6'h02
`define GRX_A_PA_MASK     6'h03
`define GRX_A_PB_MASK     6'h04
`define GRX_A_PIN_CFG     6'h05
`define GRX_A_HOLD_CFG    6'h06
`define GRX_A_TMO_VAL     6'h07
`define GRX_A_THR_X       6'h08
`define GRX_A_THR_Y       6'h09
`define GRX_A_THR_Z       6'h0A
`define GRX_A_RSEL_X      6'h0B
`define GRX_A_RSEL_Y      6'h0C
`define GRX_A_RSEL_Z      6'h0D
`define GRX_A_DEB_X       6'h0E
`define GRX_A_DEB_Y       6'h0F
`define GRX_A_DEB_Z       6'h10
`define GRX_A_RATE_CFG    6'h11
`define GRX_A_FREEZE      6'h12

// reset value of every writable register
`define GRX_RST_BYTE      8'h00

// flag positions
`define GRX_F_NEW_SAMPLE  0
`define GRX_F_RATE_ALL    1
`define GRX_F_RATE_ANY    2
`define GRX_F_EXT_LO      3
`define GRX_F_EXT_HI      7

// pin config: pin a in [2:0], pin b in [5:3]
`define GRX_PC_EN         0
`define GRX_PC_ACT_LOW    1
`define GRX_PC_OPEN_DRAIN 2
`define GRX_PC_B_BASE     3

// hold config
`define GRX_HC_A_LATCHED  0
`define GRX_HC_B_LATCHED  1

// rate config
`define GRX_RC_ALL_LO     0
`define GRX_RC_ALL_HI     2
`define GRX_RC_ANY_LO     3
`define GRX_RC_ANY_HI     5
`define GRX_RC_ONE_THR    6
`define GRX_RC_ONE_DEB    7

// freeze bit
`define GRX_FZ_EN         0

// range bit positions
`define GRX_R_HIGH_NEG    0
`define GRX_R_LOW_NEG     1
`define GRX_R_LOW_POS     2
`define GRX_R_HIGH_POS    3

// timed mode unit
`define GRX_CLK_PERIOD_NS 10
`define GRX_TMO_UNIT_NS   1000
`define GRX_TMO_TICK_CYC  ((`GRX_TMO_UNIT_NS + `GRX_CLK_PERIOD_NS - 1) / `GRX_CLK_PERIOD_NS)
`define GRX_TMO_PRE_W     7

`endif

// *** grx_irq_unit.v ***
// interrupt unit: flag routing, pin drive, hold modes and rate interrupts
//
// Local design decisions: the plain strobed port and the register offsets.
`include "grx_consts.vh"
`timescale 1ns/1ps
`default_nettype none

// one axis: range sort, debounce, readable range values
module grx_axis (
  // clock and reset
  input  wire        i_clk,
  input  wire        i_rst_b,
  // sample
  input  wire        i_smp,
  input  wire [15:0] i_data,
  // settings
  input  wire [15:0] i_thr,
  input  wire [15:0] i_deb,
  input  wire [3:0]  i_en,
  input  wire        i_freeze,
  input  wire        i_rd_clr,
  // results
  output reg  [3:0]  o_range,
  output reg         o_hit
);
  wire signed [16:0] s_val;
  wire signed [16:0] t_pos;
  wire signed [16:0] t_neg;
  wire        [3:0]  rng;
  wire               cond;
  wire        [15:0] cnt_next;
  wire        [3:0]  range_next;
  reg         [15:0] cnt_reg;

  assign s_val = {i_data[15], i_data};
  assign t_pos = {1'b0, i_thr};
  assign t_neg = -t_pos;
  // sample sorting against signed bounds
  assign rng[`GRX_R_HIGH_POS] = (s_val > t_pos);
  assign rng[`GRX_R_LOW_POS]  = ~i_data[15] & ~(s_val > t_pos);
  assign rng[`GRX_R_LOW_NEG]  = i_data[15] & ~(s_val < t_neg);
  assign rng[`GRX_R_HIGH_NEG] = (s_val < t_neg);
  assign cond = |(rng & i_en);
  // consecutive count, saturating
  assign cnt_next = cond ? ((cnt_reg == 16'hFFFF) ? cnt_reg : cnt_reg + 16'h0001)
                         : 16'h0000;
  // sticky when frozen, new sample beats read clear
  assign range_next = i_freeze ?
                      ((i_rd_clr ? 4'h0 : o_range) | (i_smp ? rng : 4'h0)) :
                      (i_smp ? rng : o_range);

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_reg <= 16'h0000;
      o_hit   <= 1'b0;
      o_range <= 4'h0;
    end else begin
      o_range <= range_next;
      if (i_smp) begin
        cnt_reg <= cnt_next;
        o_hit   <= (cnt_next != 16'h0000) && (cnt_next >= i_deb);
      end
    end
  end
endmodule

// one interrupt pin: status hold, mask, drive
module grx_pin (
  // clock and reset
  input  wire       i_clk,
  input  wire       i_rst_b,
  // flags
  input  wire [7:0] i_raw,
  input  wire [7:0] i_mask,
  // hold control
  input  wire       i_latched,
  input  wire [7:0] i_tmo,
  input  wire       i_tick,
  input  wire       i_rd_clr,
  // drive settings
  input  wire       i_en,
  input  wire       i_act_low,
  input  wire       i_open_drain,
  // outputs
  output reg  [7:0] o_status,
  output reg        o_pin,
  output reg        o_oe
);
  localparam [7:0] HOLD_BITS = ~(8'h01 << `GRX_F_NEW_SAMPLE);

  reg  [7:0] tmr_reg;
  reg        run_reg;
  wire [7:0] held;
  wire       expire;
  wire       live;
  wire [7:0] keep;
  wire [7:0] status_next;
  wire       asserted;

  // new sample flag is never held
  assign held   = o_status & HOLD_BITS;
  assign live   = |(i_raw & HOLD_BITS);
  assign expire = run_reg & i_tick & (tmr_reg == 8'h00);
  // latched: clear on status read; timed: clear on expiry
  assign keep   = i_latched ? (i_rd_clr ? 8'h00 : held) :
                              (expire ? 8'h00 : held);
  // present events always win over a clear
  assign status_next = i_raw | keep;
  assign asserted = |(status_next & i_mask);

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_status <= 8'h00;
      tmr_reg  <= 8'h00;
      run_reg  <= 1'b0;
      o_pin    <= 1'b0;
      o_oe     <= 1'b0;
    end else begin
      o_status <= status_next;
      // duration counts from the last raised held flag, so no bit sticks
      if (!i_latched && (live || ((|held) && !run_reg))) begin
        tmr_reg <= i_tmo;
        run_reg <= 1'b1;
      end else if (run_reg && i_tick) begin
        if (tmr_reg == 8'h00) begin
          run_reg <= 1'b0;
        end else begin
          tmr_reg <= tmr_reg - 8'h01;
        end
      end
      // drive style
      if (!i_en) begin
        o_pin <= 1'b0;
        o_oe  <= 1'b0;
      end else if (i_open_drain) begin
        o_pin <= 1'b0;
        o_oe  <= asserted ? i_act_low : ~i_act_low;
      end else begin
        o_pin <= asserted ^ i_act_low;
        o_oe  <= 1'b1;
      end
    end
  end
endmodule

// top level
module grx_irq_unit (
  // clock and reset
  input  wire        i_ref_clk,
  input  wire        i_rst_b,
  // register port
  input  wire [5:0]  i_reg_addr,
  input  wire [7:0]  i_reg_wdata,
  input  wire        i_reg_wr,
  input  wire        i_reg_rd,
  output reg  [7:0]  o_reg_rdata,
  // samples
  input  wire        i_sample_valid,
  input  wire [15:0] i_sample_x,
  input  wire [15:0] i_sample_y,
  input  wire [15:0] i_sample_z,
  // other event levels
  input  wire [4:0]  i_ext_event,
  // interrupt pins
  output wire        o_irq_pin_a,
  output wire        o_irq_pin_a_oe,
  output wire        o_irq_pin_b,
  output wire        o_irq_pin_b_oe,
  // rate interrupt levels
  output reg         o_rate_all,
  output reg         o_rate_any
);
  localparam integer TICK_LAST_I = `GRX_TMO_TICK_CYC - 1;
  localparam [`GRX_TMO_PRE_W-1:0] TICK_LAST = TICK_LAST_I[`GRX_TMO_PRE_W-1:0];

  reg  [7:0] pa_mask_reg;
  reg  [7:0] pb_mask_reg;
  reg  [7:0] pin_cfg_reg;
  reg  [7:0] hold_cfg_reg;
  reg  [7:0] tmo_val_reg;
  reg  [7:0] thr_x_reg;
  reg  [7:0] thr_y_reg;
  reg  [7:0] thr_z_reg;
  reg  [7:0] rsel_x_reg;
  reg  [7:0] rsel_y_reg;
  reg  [7:0] rsel_z_reg;
  reg  [7:0] deb_x_reg;
  reg  [7:0] deb_y_reg;
  reg  [7:0] deb_z_reg;
  reg  [7:0] rate_cfg_reg;
  reg  [7:0] freeze_reg;
  reg        new_sample_reg;
  reg  [`GRX_TMO_PRE_W-1:0] pre_reg;

  wire       tick;
  wire       rd_ul;
  wire       rd_pa;
  wire       rd_pb;
  wire [7:0] raw_flags;
  wire [7:0] pa_status;
  wire [7:0] pb_status;
  wire       one_thr;
  wire       one_deb;
  wire [15:0] thr_x;
  wire [15:0] thr_y;
  wire [15:0] thr_z;
  wire [15:0] deb_x;
  wire [15:0] deb_y;
  wire [15:0] deb_z;
  wire [3:0] rng_x;
  wire [3:0] rng_y;
  wire [3:0] rng_z;
  wire [2:0] hit;
  wire [2:0] all_axes;
  wire [2:0] any_axes;
  wire [2:0] pa_cfg;
  wire [2:0] pb_cfg;

  assign rd_ul = i_reg_rd && (i_reg_addr == `GRX_A_UL_STS);
  assign rd_pa = i_reg_rd && (i_reg_addr == `GRX_A_PA_STS);
  assign rd_pb = i_reg_rd && (i_reg_addr == `GRX_A_PB_STS);
  assign tick  = (pre_reg == TICK_LAST);

  assign one_thr = rate_cfg_reg[`GRX_RC_ONE_THR];
  assign one_deb = rate_cfg_reg[`GRX_RC_ONE_DEB];
  // threshold high byte or debounce low byte per axis, or one shared 16-bit value
  assign thr_x = one_thr ? {thr_x_reg, thr_y_reg} : {thr_x_reg, 8'h00};
  assign thr_y = one_thr ? {thr_x_reg, thr_y_reg} : {thr_y_reg, 8'h00};
  assign thr_z = one_thr ? {thr_x_reg, thr_y_reg} : {thr_z_reg, 8'h00};
  assign deb_x = one_deb ? {deb_x_reg, deb_y_reg} : {8'h00, deb_x_reg};
  assign deb_y = one_deb ? {deb_x_reg, deb_y_reg} : {8'h00, deb_y_reg};
  assign deb_z = one_deb ? {deb_x_reg, deb_y_reg} : {8'h00, deb_z_reg};

  assign all_axes = rate_cfg_reg[`GRX_RC_ALL_HI:`GRX_RC_ALL_LO];
  assign any_axes = rate_cfg_reg[`GRX_RC_ANY_HI:`GRX_RC_ANY_LO];

  assign raw_flags[`GRX_F_NEW_SAMPLE] = new_sample_reg;
  assign raw_flags[`GRX_F_RATE_ALL]   = o_rate_all;
  assign raw_flags[`GRX_F_RATE_ANY]   = o_rate_any;
  assign raw_flags[`GRX_F_EXT_HI:`GRX_F_EXT_LO] = i_ext_event;

  // independent settings per pin
  assign pa_cfg = pin_cfg_reg[2:0];
  assign pb_cfg = pin_cfg_reg[`GRX_PC_B_BASE+2:`GRX_PC_B_BASE];

  grx_axis u_axis_x (
    .i_clk    (i_ref_clk),
    .i_rst_b  (i_rst_b),
    .i_smp    (i_sample_valid),
    .i_data   (i_sample_x),
    .i_thr    (thr_x),
    .i_deb    (deb_x),
    .i_en     (rsel_x_reg[3:0]),
    .i_freeze (freeze_reg[`GRX_FZ_EN]),
    .i_rd_clr (i_reg_rd && (i_reg_addr == `GRX_A_RSEL_X)),
    .o_range  (rng_x),
    .o_hit    (hit[0])
  );

  grx_axis u_axis_y (
    .i_clk    (i_ref_clk),
    .i_rst_b  (i_rst_b),
    .i_smp    (i_sample_valid),
    .i_data   (i_sample_y),
    .i_thr    (thr_y),
    .i_deb    (deb_y),
    .i_en     (rsel_y_reg[3:0]),
    .i_freeze (freeze_reg[`GRX_FZ_EN]),
    .i_rd_clr (i_reg_rd && (i_reg_addr == `GRX_A_RSEL_Y)),
    .o_range  (rng_y),
    .o_hit    (hit[1])
  );

  grx_axis u_axis_z (
    .i_clk    (i_ref_clk),
    .i_rst_b  (i_rst_b),
    .i_smp    (i_sample_valid),
    .i_data   (i_sample_z),
    .i_thr    (thr_z),
    .i_deb    (deb_z),
    .i_en     (rsel_z_reg[3:0]),
    .i_freeze (freeze_reg[`GRX_FZ_EN]),
    .i_rd_clr (i_reg_rd && (i_reg_addr == `GRX_A_RSEL_Z)),
    .o_range  (rng_z),
    .o_hit    (hit[2])
  );

  grx_pin u_pin_a (
    .i_clk        (i_ref_clk),
    .i_rst_b      (i_rst_b),
    .i_raw        (raw_flags),
    .i_mask       (pa_mask_reg),
    .i_latched    (hold_cfg_reg[`GRX_HC_A_LATCHED]),
    .i_tmo        (tmo_val_reg),
    .i_tick       (tick),
    .i_rd_clr     (rd_pa),
    .i_en         (pa_cfg[`GRX_PC_EN]),
    .i_act_low    (pa_cfg[`GRX_PC_ACT_LOW]),
    .i_open_drain (pa_cfg[`GRX_PC_OPEN_DRAIN]),
    .o_status     (pa_status),
    .o_pin        (o_irq_pin_a),
    .o_oe         (o_irq_pin_a_oe)
  );

  grx_pin u_pin_b (
    .i_clk        (i_ref_clk),
    .i_rst_b      (i_rst_b),
    .i_raw        (raw_flags),
    .i_mask       (pb_mask_reg),
    .i_latched    (hold_cfg_reg[`GRX_HC_B_LATCHED]),
    .i_tmo        (tmo_val_reg),
    .i_tick       (tick),
    .i_rd_clr     (rd_pb),
    .i_en         (pb_cfg[`GRX_PC_EN]),
    .i_act_low    (pb_cfg[`GRX_PC_ACT_LOW]),
    .i_open_drain (pb_cfg[`GRX_PC_OPEN_DRAIN]),
    .o_status     (pb_status),
    .o_pin        (o_irq_pin_b),
    .o_oe         (o_irq_pin_b_oe)
  );

  // flags, rate combine, timed-mode prescaler
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      new_sample_reg <= 1'b0;
      o_rate_all     <= 1'b0;
      o_rate_any     <= 1'b0;
      pre_reg        <= {`GRX_TMO_PRE_W{1'b0}};
    end else begin
      // new sample beats the clearing read
      new_sample_reg <= i_sample_valid | (new_sample_reg & ~rd_ul);
      o_rate_all <= (|all_axes) & (&(hit | ~all_axes));
      o_rate_any <= |(hit & any_axes);
      pre_reg    <= tick ? {`GRX_TMO_PRE_W{1'b0}} : pre_reg + 1'b1;
    end
  end

  // register writes
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pa_mask_reg  <= `GRX_RST_BYTE;
      pb_mask_reg  <= `GRX_RST_BYTE;
      pin_cfg_reg  <= `GRX_RST_BYTE;
      hold_cfg_reg <= `GRX_RST_BYTE;
      tmo_val_reg  <= `GRX_RST_BYTE;
      thr_x_reg    <= `GRX_RST_BYTE;
      thr_y_reg    <= `GRX_RST_BYTE;
      thr_z_reg    <= `GRX_RST_BYTE;
      rsel_x_reg   <= `GRX_RST_BYTE;
      rsel_y_reg   <= `GRX_RST_BYTE;
      rsel_z_reg   <= `GRX_RST_BYTE;
      deb_x_reg    <= `GRX_RST_BYTE;
      deb_y_reg    <= `GRX_RST_BYTE;
      deb_z_reg    <= `GRX_RST_BYTE;
      rate_cfg_reg <= `GRX_RST_BYTE;
      freeze_reg   <= `GRX_RST_BYTE;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        `GRX_A_PA_MASK:  pa_mask_reg  <= i_reg_wdata;
        `GRX_A_PB_MASK:  pb_mask_reg  <= i_reg_wdata;
        `GRX_A_PIN_CFG:  pin_cfg_reg  <= {2'b00, i_reg_wdata[5:0]};
        `GRX_A_HOLD_CFG: hold_cfg_reg <= {6'h00, i_reg_wdata[1:0]};
        `GRX_A_TMO_VAL:  tmo_val_reg  <= i_reg_wdata;
        `GRX_A_THR_X:    thr_x_reg    <= i_reg_wdata;
        `GRX_A_THR_Y:    thr_y_reg    <= i_reg_wdata;
        `GRX_A_THR_Z:    thr_z_reg    <= i_reg_wdata;
        `GRX_A_RSEL_X:   rsel_x_reg   <= {4'h0, i_reg_wdata[3:0]};
        `GRX_A_RSEL_Y:   rsel_y_reg   <= {4'h0, i_reg_wdata[3:0]};
        `GRX_A_RSEL_Z:   rsel_z_reg   <= {4'h0, i_reg_wdata[3:0]};
        `GRX_A_DEB_X:    deb_x_reg    <= i_reg_wdata;
        `GRX_A_DEB_Y:    deb_y_reg    <= i_reg_wdata;
        `GRX_A_DEB_Z:    deb_z_reg    <= i_reg_wdata;
        `GRX_A_RATE_CFG: rate_cfg_reg <= i_reg_wdata;
        `GRX_A_FREEZE:   freeze_reg   <= {7'h00, i_reg_wdata[0]};
        default: begin
        end
      endcase
    end
  end

  // read data, one cycle after the strobe; unmapped reads zero
  always @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `GRX_A_UL_STS:   o_reg_rdata <= raw_flags;
        `GRX_A_PA_STS:   o_reg_rdata <= pa_status;
        `GRX_A_PB_STS:   o_reg_rdata <= pb_status;
        `GRX_A_PA_MASK:  o_reg_rdata <= pa_mask_reg;
        `GRX_A_PB_MASK:  o_reg_rdata <= pb_mask_reg;
        `GRX_A_PIN_CFG:  o_reg_rdata <= pin_cfg_reg;
        `GRX_A_HOLD_CFG: o_reg_rdata <= hold_cfg_reg;
        `GRX_A_TMO_VAL:  o_reg_rdata <= tmo_val_reg;
        `GRX_A_THR_X:    o_reg_rdata <= thr_x_reg;
        `GRX_A_THR_Y:    o_reg_rdata <= thr_y_reg;
        `GRX_A_THR_Z:    o_reg_rdata <= thr_z_reg;
        // range values beside enables
        `GRX_A_RSEL_X:   o_reg_rdata <= {rng_x, rsel_x_reg[3:0]};
        `GRX_A_RSEL_Y:   o_reg_rdata <= {rng_y, rsel_y_reg[3:0]};
        `GRX_A_RSEL_Z:   o_reg_rdata <= {rng_z, rsel_z_reg[3:0]};
        `GRX_A_DEB_X:    o_reg_rdata <= deb_x_reg;
        `GRX_A_DEB_Y:    o_reg_rdata <= deb_y_reg;
        `GRX_A_DEB_Z:    o_reg_rdata <= deb_z_reg;
        `GRX_A_RATE_CFG: o_reg_rdata <= rate_cfg_reg;
        `GRX_A_FREEZE:   o_reg_rdata <= freeze_reg;
        default:         o_reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule

`default_nettype wire

// *** grx_irq_unit_props.sv ***
// port assertions for the rate sensor interrupt unit
`timescale 1ns/1ps
`default_nettype none
`include "grx_consts.vh"
module grx_irq_props (
  // clock and reset
  input wire logic        i_ref_clk,
  input wire logic        i_rst_b,
  // register port
  input wire logic [5:0]  i_reg_addr,
  input wire logic [7:0]  i_reg_wdata,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [7:0]  o_reg_rdata,
  // samples and events
  input wire logic        i_sample_valid,
  input wire logic [15:0] i_sample_x,
  input wire logic [15:0] i_sample_y,
  input wire logic [15:0] i_sample_z,
  input wire logic [4:0]  i_ext_event,
  // pins and rate levels
  input wire logic        o_irq_pin_a,
  input wire logic        o_irq_pin_a_oe,
  input wire logic        o_irq_pin_b,
  input wire logic        o_irq_pin_b_oe,
  input wire logic        o_rate_all,
  input wire logic        o_rate_any
);
  logic [7:0] mask_a_reg;

  // shadow of the pin a mask as written
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mask_a_reg <= `GRX_RST_BYTE;
    end else if (i_reg_wr && i_reg_addr == `GRX_A_PA_MASK) begin
      mask_a_reg <= i_reg_wdata;
    end
  end

  default clocking dcb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  a_reset_quiet: assert property ($rose(i_rst_b) |->
    !(o_irq_pin_a_oe || o_irq_pin_b_oe || o_rate_all || o_rate_any))
    else $error("outputs active right after reset");
  a_pin_a_drive: assert property (o_irq_pin_a |-> o_irq_pin_a_oe)
    else $error("pin a high while not driven");
  a_pin_b_drive: assert property (o_irq_pin_b |-> o_irq_pin_b_oe)
    else $error("pin b high while not driven");
  a_rate_all_cause: assert property ($changed(o_rate_all) |->
    $past(i_sample_valid) || $past(i_sample_valid, 2) || $past(i_reg_wr) || $past(i_reg_wr, 2))
    else $error("all-axes level moved without sample or write");
  a_rate_any_cause: assert property ($changed(o_rate_any) |->
    $past(i_sample_valid) || $past(i_sample_valid, 2) || $past(i_reg_wr) || $past(i_reg_wr, 2))
    else $error("any-axis level moved without sample or write");
  a_cfg_reserved: assert property (
    i_reg_rd && i_reg_addr == `GRX_A_PIN_CFG |=> o_reg_rdata[7:6] == 2'h0)
    else $error("pin config reserved bits read nonzero");
  a_hold_reserved: assert property (
    i_reg_rd && i_reg_addr == `GRX_A_HOLD_CFG |=> o_reg_rdata[7:2] == 6'h00)
    else $error("hold config reserved bits read nonzero");
  a_mask_readback: assert property (
    i_reg_rd && i_reg_addr == `GRX_A_PA_MASK |=> o_reg_rdata == $past(mask_a_reg))
    else $error("pin a mask reads back wrong");
  a_status_shows: assert property (
    i_reg_rd && i_reg_addr == `GRX_A_PB_STS && $stable(i_ext_event) && $past(i_rst_b)
    |=> (o_reg_rdata[7:3] & $past(i_ext_event)) == $past(i_ext_event))
    else $error("pin b status misses a present event");
endmodule

bind grx_irq_unit grx_irq_props props_u (
  .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .i_sample_valid(i_sample_valid), .i_sample_x(i_sample_x),
  .i_sample_y(i_sample_y), .i_sample_z(i_sample_z), .i_ext_event(i_ext_event),
  .o_irq_pin_a(o_irq_pin_a), .o_irq_pin_a_oe(o_irq_pin_a_oe), .o_irq_pin_b(o_irq_pin_b),
  .o_irq_pin_b_oe(o_irq_pin_b_oe), .o_rate_all(o_rate_all), .o_rate_any(o_rate_any)
);
`default_nettype wire

// *** grx_irq_host.sv ***
// host side view of one interrupt line
`timescale 1ns/1ps
`default_nettype none
module grx_irq_host (
  // line from the unit
  input  wire logic i_pin,
  input  wire logic i_oe,
  // level the host sees
  output logic      o_line
);
  // released line floats up through the board pull-up
  assign o_line = i_oe ? i_pin : 1'b1;
endmodule
`default_nettype wire

// *** grx_irq_unit_tb.sv ***
// self-checking bench for the rate sensor interrupt unit
`timescale 1ns/1ps
`default_nettype none
`include "grx_consts.vh"
module grx_irq_unit_tb;
  logic        i_ref_clk = 1'b0;
  logic        i_rst_b, i_reg_wr, i_reg_rd, i_sample_valid;
  logic [5:0]  i_reg_addr;
  logic [7:0]  i_reg_wdata, o_reg_rdata, d;
  logic [15:0] i_sample_x, i_sample_y, i_sample_z;
  logic [4:0]  i_ext_event;
  logic        o_irq_pin_a, o_irq_pin_a_oe, o_irq_pin_b, o_irq_pin_b_oe;
  logic        o_rate_all, o_rate_any, line_a, line_b;
  int          bad_count = 0;
  int          compares = 0;
  int          cyc = 0;
  // x sample, range bits, rate level with high ranges enabled
  logic [20:0] rows [6] = '{{16'h0101, 4'h8, 1'h1}, {16'h0100, 4'h4, 1'h0},
    {16'h0000, 4'h4, 1'h0}, {16'hFFFF, 4'h2, 1'h0}, {16'hFF00, 4'h2, 1'h0},
    {16'hFEFF, 4'h1, 1'h1}};

  always #5 i_ref_clk = ~i_ref_clk;

  grx_irq_unit dut_u (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_sample_valid(i_sample_valid), .i_sample_x(i_sample_x),
    .i_sample_y(i_sample_y), .i_sample_z(i_sample_z), .i_ext_event(i_ext_event),
    .o_irq_pin_a(o_irq_pin_a), .o_irq_pin_a_oe(o_irq_pin_a_oe), .o_irq_pin_b(o_irq_pin_b),
    .o_irq_pin_b_oe(o_irq_pin_b_oe), .o_rate_all(o_rate_all), .o_rate_any(o_rate_any)
  );
  grx_irq_host host_a_u (.i_pin(o_irq_pin_a), .i_oe(o_irq_pin_a_oe), .o_line(line_a));
  grx_irq_host host_b_u (.i_pin(o_irq_pin_b), .i_oe(o_irq_pin_b_oe), .o_line(line_b));

  task wrap_up;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge i_ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 10000) begin
      bad_count++;
      wrap_up();
    end
  end

  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wt(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  task wr(input logic [5:0] a, input logic [7:0] v);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= v;
    wt(1);
    i_reg_wr <= 1'b0;
    wt(1);
  endtask

  // read data appear in the cycle after the strobe and hold until the next read
  task rc(input logic [5:0] a, input logic [7:0] m, input logic [7:0] e);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    wt(1);
    d = o_reg_rdata;
    i_reg_rd <= 1'b0;
    wt(1);
    chk($sformatf("reg %h", a), d & m, e);
  endtask

  task smp(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
    i_sample_valid <= 1'b1;
    i_sample_x <= x;
    i_sample_y <= y;
    i_sample_z <= z;
    wt(1);
    i_sample_valid <= 1'b0;
    wt(1);
  endtask

  task rt(input logic a, input logic y);
    chk("rate all", {7'h00, o_rate_all}, {7'h00, a});
    chk("rate any", {7'h00, o_rate_any}, {7'h00, y});
  endtask

  // pin b stays push-pull, active high, with an all-zero mask
  task pc(input logic [2:0] c, input logic [1:0] e);
    wr(`GRX_A_PIN_CFG, {5'h01, c});
    chk("pin a", {6'h00, line_a, o_irq_pin_a_oe}, {6'h00, e});
    chk("pin b", {6'h00, line_b, o_irq_pin_b_oe}, 8'h01);
  endtask

  initial begin
    i_rst_b = 1'b0;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    i_reg_addr = 6'h00;
    i_reg_wdata = 8'h00;
    i_sample_valid = 1'b0;
    i_sample_x = 16'h0000;
    i_sample_y = 16'h0000;
    i_sample_z = 16'h0000;
    i_ext_event = 5'h00;
    repeat (16) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    wt(1);
    wr(`GRX_A_THR_X, 8'h01);
    wr(`GRX_A_RSEL_X, 8'h09);
    wr(`GRX_A_RATE_CFG, 8'h09);
    for (int i = 0; i < 6; i++) begin
      smp(rows[i][20:5], 16'h0000, 16'h0000);
      rt(rows[i][0], rows[i][0]);
      rc(`GRX_A_RSEL_X, 8'hF0, {rows[i][4:1], 4'h0});
    end
    // second reset in mid-run
    i_rst_b <= 1'b0;
    wt(3);
    i_rst_b <= 1'b1;
    wt(1);
    rt(1'b0, 1'b0);
    chk("pins idle", {6'h00, o_irq_pin_a_oe, o_irq_pin_b_oe}, 8'h00);
    for (int a = 3; a <= 18; a++) begin
      rc(a[5:0], 8'hFF, 8'h00);
    end
    rc(6'h3F, 8'hFF, 8'h00);
    wr(`GRX_A_PA_STS, 8'hFF);
    rc(`GRX_A_PA_STS, 8'hFF, 8'h00);
    wr(`GRX_A_PIN_CFG, 8'hFF);
    rc(`GRX_A_PIN_CFG, 8'hFF, 8'h3F);
    wr(`GRX_A_HOLD_CFG, 8'hFF);
    rc(`GRX_A_HOLD_CFG, 8'hFF, 8'h03);
    wr(`GRX_A_HOLD_CFG, 8'h00);
    wr(`GRX_A_PA_MASK, 8'h08);
    rc(`GRX_A_PA_MASK, 8'hFF, 8'h08);
    pc(3'h1, 2'h1);
    i_ext_event <= 5'h01;
    wt(2);
    pc(3'h1, 2'h3);
    pc(3'h0, 2'h2);
    pc(3'h3, 2'h1);
    pc(3'h5, 2'h2);
    pc(3'h7, 2'h1);
    wr(`GRX_A_PA_MASK, 8'h00);
    pc(3'h1, 2'h1);
    rc(`GRX_A_PB_STS, 8'hF8, 8'h08);
    wr(`GRX_A_PA_MASK, 8'h08);
    i_ext_event <= 5'h00;
    wt(400);
    rc(`GRX_A_PB_STS, 8'hF8, 8'h00);
    wr(`GRX_A_HOLD_CFG, 8'h01);
    i_ext_event <= 5'h01;
    wt(2);
    i_ext_event <= 5'h00;
    wt(400);
    rc(`GRX_A_PA_STS, 8'hF8, 8'h08);
    rc(`GRX_A_PA_STS, 8'hF8, 8'h00);
    chk("pin a line", {7'h00, line_a}, 8'h00);
    i_ext_event <= 5'h01;
    wt(2);
    rc(`GRX_A_PA_STS, 8'hF8, 8'h08);
    rc(`GRX_A_PA_STS, 8'hF8, 8'h08);
    i_ext_event <= 5'h00;
    wt(2);
    rc(`GRX_A_PA_STS, 8'hF8, 8'h08);
    rc(`GRX_A_PA_STS, 8'hF8, 8'h00);
    wr(`GRX_A_HOLD_CFG, 8'h00);
    wr(`GRX_A_TMO_VAL, 8'h02);
    i_ext_event <= 5'h01;
    wt(2);
    i_ext_event <= 5'h00;
    wt(`GRX_TMO_TICK_CYC * 3 / 2);
    rc(`GRX_A_PA_STS, 8'hF8, 8'h08);
    wt(`GRX_TMO_TICK_CYC * 2);
    rc(`GRX_A_PA_STS, 8'hF8, 8'h00);
    wr(`GRX_A_HOLD_CFG, 8'h03);
    smp(16'h0000, 16'h0000, 16'h0000);
    rc(`GRX_A_PA_STS, 8'h01, 8'h01);
    rc(`GRX_A_UL_STS, 8'h01, 8'h01);
    rc(`GRX_A_PA_STS, 8'h01, 8'h00);
    rc(`GRX_A_PB_STS, 8'h01, 8'h00);
    wr(`GRX_A_THR_X, 8'h01);
    wr(`GRX_A_THR_Y, 8'h01);
    wr(`GRX_A_THR_Z, 8'h01);
    wr(`GRX_A_RSEL_X, 8'h08);
    wr(`GRX_A_RSEL_Y, 8'h08);
    wr(`GRX_A_RSEL_Z, 8'h08);
    wr(`GRX_A_RATE_CFG, 8'h3F);
    smp(16'h0101, 16'h0000, 16'h0101);
    rt(1'b0, 1'b1);
    smp(16'h0101, 16'h0101, 16'h0101);
    rt(1'b1, 1'b1);
    wr(`GRX_A_RATE_CFG, 8'h15);
    smp(16'h0101, 16'h0000, 16'h0101);
    rt(1'b1, 1'b0);
    wr(`GRX_A_THR_X, 8'h00);
    wr(`GRX_A_THR_Y, 8'h10);
    wr(`GRX_A_RATE_CFG, 8'h48);
    smp(16'h0010, 16'h0000, 16'h0000);
    rt(1'b0, 1'b0);
    smp(16'h0011, 16'h0000, 16'h0000);
    rt(1'b0, 1'b1);
    wr(`GRX_A_RATE_CFG, 8'h08);
    wr(`GRX_A_DEB_X, 8'h03);
    for (int i = 0; i < 8; i++) begin
      smp(8'hEE >> i & 1 ? 16'h0011 : 16'h0000, 16'h0000, 16'h0000);
      rt(1'b0, i == 3 || i == 7);
    end
    wr(`GRX_A_DEB_X, 8'h01);
    wr(`GRX_A_DEB_Y, 8'h00);
    wr(`GRX_A_RATE_CFG, 8'h88);
    smp(16'h0000, 16'h0000, 16'h0000);
    repeat (255) smp(16'h0011, 16'h0000, 16'h0000);
    rt(1'b0, 1'b0);
    smp(16'h0011, 16'h0000, 16'h0000);
    rt(1'b0, 1'b1);
    wr(`GRX_A_RATE_CFG, 8'h00);
    wr(`GRX_A_THR_X, 8'h01);
    wr(`GRX_A_FREEZE, 8'h01);
    rc(`GRX_A_RSEL_X, 8'hF0, 8'h80);
    smp(16'h0101, 16'h0000, 16'h0000);
    smp(16'h0000, 16'h0000, 16'h0000);
    rc(`GRX_A_RSEL_X, 8'hF0, 8'hC0);
    rc(`GRX_A_RSEL_X, 8'hF0, 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
